// *** hw/cmtr_trigger_reaction.sv ***
// Connection-management trigger reaction with its APB register file.
// Assumes the received conditions arrive as levels from another clock
// domain and that pclk is the local byte clock.
// While the clock enable is low nothing moves, the trigger included.
//
// What this block does
// - The upper field of the trigger definition picks which received conditions fire the trigger.
// - A met trigger condition sets the trigger occurred flag.
// - A trigger copies the three-bit transmit code into the current transmit state.
// - Code 110 means quiet line state is transmitted on a trigger.
// - With its mask set, each new trigger occurred flag sets the connection service event.
// - The condition set holds condition and mask registers that govern the interrupt, and a compare register that is plain storage.
// - A trigger loads the transition configuration into the switch configuration.
// - Any enabled condition also enables the switch reload.
// - Software writes to the switch configuration are ignored while the reload happens.
// - The break line state is applied well within 3.0 ms.
// - The switch reload completes well within 3.0 ms.
`timescale 1ns/1ps
`default_nettype none
module cmtr_trigger_reaction
    import cmtr_pkg::*;
#(
    parameter int NUM_COND = CMTR_NUM_COND
) (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received conditions from the line-state detector
    input wire logic rx_super_idle,
    input wire logic rx_master,
    input wire logic rx_halt,
    input wire logic rx_quiet,
    input wire logic rx_noise_threshold,
    // Reaction outputs
    output logic [2:0] tx_line_state,
    output logic [7:0] switch_config,
    output logic trigger_pulse,
    output logic irq
);

    // Register state
    logic [7:0] trigger_definition_q;
    logic [7:0] trigger_transition_config_q;
    logic [7:0] switch_configuration_q;
    logic [2:0] current_transmit_state_q;
    logic trigger_occurred_q;
    logic [7:0] cmt_condition_compare_q;
    logic trigger_occurred_mask_q;
    logic connection_service_event_q;
    logic connection_service_event_mask_q;
    logic fire_q;
    logic trigger_pulse_q;
    logic [31:0] prdata_q;

    // Bus decode
    logic acc;
    logic wr;
    logic mapped;
    logic [31:0] rd_d;

    // Trigger decode
    logic [NUM_COND-1:0] raw_cond;
    logic [NUM_COND-1:0] enables;
    logic fire;
    logic trig;
    logic tco_set;
    logic cse_set;

    cmtr_cond_if #(.W(NUM_COND)) cond_bus ();

    // Pack raw conditions in enable field order
    // Noise threshold sits in the lowest enable bit, super idle in the top
    always_comb
    begin
        raw_cond = '0;
        raw_cond[CMTR_COND_NOISE_THRESHOLD] = rx_noise_threshold;
        raw_cond[CMTR_COND_QUIET] = rx_quiet;
        raw_cond[CMTR_COND_HALT] = rx_halt;
        raw_cond[CMTR_COND_MASTER] = rx_master;
        raw_cond[CMTR_COND_SUPER_IDLE] = rx_super_idle;
    end

    // Conditions come from the receive domain, so synchronise them first
    // Bits may settle one cycle apart; any single enabled bit is enough to fire
    cmtr_sync #(
        .W(NUM_COND)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .raw(raw_cond),
        .out(cond_bus)
    );

    // Condition selection, one evaluation per byte clock
    assign enables = trigger_definition_q[CMTR_TD_EN_LSB +: NUM_COND];
    assign fire = |(enables & cond_bus.cond);

    // Trigger is the first cycle of a selected condition; a persisting
    // condition does not keep locking out software writes
    assign trig = fire && !fire_q;

    // Last fire level and the one-cycle pulse that marks a trigger
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fire_q <= 1'b0;
            trigger_pulse_q <= 1'b0;
        end
        else if (ce)
        begin
            fire_q <= fire;
            trigger_pulse_q <= trig;
        end
    end

    // APB: one wait-free access phase unless the clock enable is low
    // Only the address can refuse an access, never its timing
    assign acc = psel && penable && ce;
    assign wr = acc && pwrite;

    always_comb
    begin
        mapped = 1'b1;
        rd_d = 32'h00000000;
        unique case (paddr)
            CMTR_OFF_TRIGGER_DEFINITION: rd_d[7:0] = trigger_definition_q;
            CMTR_OFF_TRIGGER_TRANSITION_CONFIG: rd_d[7:0] = trigger_transition_config_q;
            CMTR_OFF_SWITCH_CONFIGURATION: rd_d[7:0] = switch_configuration_q;
            CMTR_OFF_CURRENT_TRANSMIT_STATE: rd_d[2:0] = current_transmit_state_q;
            CMTR_OFF_CMT_CONDITION: rd_d[CMTR_TRIGGER_OCCURRED_BIT] = trigger_occurred_q;
            CMTR_OFF_CMT_CONDITION_COMPARE: rd_d[7:0] = cmt_condition_compare_q;
            CMTR_OFF_CMT_CONDITION_MASK: rd_d[CMTR_TRIGGER_OCCURRED_BIT] = trigger_occurred_mask_q;
            CMTR_OFF_RECEIVE_CONDITION_B:
                rd_d[CMTR_CONNECTION_SERVICE_EVENT_BIT] = connection_service_event_q;
            CMTR_OFF_RECEIVE_CONDITION_MASK_B:
                rd_d[CMTR_CONNECTION_SERVICE_EVENT_BIT] = connection_service_event_mask_q;
            default: mapped = 1'b0;
        endcase
    end

    // Read data sampled every selected cycle so it is a flop at access
    // Trade-off: one flop stage instead of a wait state keeps APB zero-wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
        end
        else if (ce && psel)
        begin
            prdata_q <= rd_d;
        end
    end

    assign prdata = prdata_q;
    // Stall the master while the clock enable freezes the block
    assign pready = ce;
    // A master reads pslverr only with pready, so it needs no ce term
    assign pslverr = psel && penable && !mapped;

    // Trigger definition: enables on top, transmit code below; enabling a
    // condition that is already present fires on the next cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trigger_definition_q <= CMTR_RST_TRIGGER_DEFINITION;
        end
        else if (wr && paddr == CMTR_OFF_TRIGGER_DEFINITION)
        begin
            trigger_definition_q <= pwdata[7:0];
        end
    end

    // Transition configuration, software only; it is applied on every
    // trigger, so it must hold the present or the fallback setting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trigger_transition_config_q <= CMTR_RST_TRANSITION_CONFIG;
        end
        else if (wr && paddr == CMTR_OFF_TRIGGER_TRANSITION_CONFIG)
        begin
            trigger_transition_config_q <= pwdata[7:0];
        end
    end

    // Condition compare, plain storage read back by software; nothing
    // in the trigger path looks at it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmt_condition_compare_q <= CMTR_RST_BYTE;
        end
        else if (wr && paddr == CMTR_OFF_CMT_CONDITION_COMPARE)
        begin
            cmt_condition_compare_q <= pwdata[7:0];
        end
    end

    // Condition mask: decides whether a new trigger also raises the
    // service event
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trigger_occurred_mask_q <= 1'b0;
        end
        else if (wr && paddr == CMTR_OFF_CMT_CONDITION_MASK)
        begin
            trigger_occurred_mask_q <= pwdata[CMTR_TRIGGER_OCCURRED_BIT];
        end
    end

    // Service event mask: gates only the interrupt pin, the event bit
    // itself still sets so software can poll it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            connection_service_event_mask_q <= 1'b0;
        end
        else if (wr && paddr == CMTR_OFF_RECEIVE_CONDITION_MASK_B)
        begin
            connection_service_event_mask_q <= pwdata[CMTR_CONNECTION_SERVICE_EVENT_BIT];
        end
    end

    // Switch configuration: the reload wins and blocks a same-cycle write
    // A later write is taken as usual, only the trigger cycle is locked
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            switch_configuration_q <= CMTR_RST_SWITCH_CONFIGURATION;
        end
        else if (ce)
        begin
            if (trig)
            begin
                switch_configuration_q <= trigger_transition_config_q;
            end
            else if (wr && paddr == CMTR_OFF_SWITCH_CONFIGURATION)
            begin
                switch_configuration_q <= pwdata[7:0];
            end
        end
    end

    // Current transmit state: the trigger code applies at once, so quiet
    // (code 110) goes out on the cycle after the trigger
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            current_transmit_state_q <= CMTR_RST_TRANSMIT_STATE;
        end
        else if (ce)
        begin
            if (trig)
            begin
                current_transmit_state_q <=
                    trigger_definition_q[CMTR_TD_CODE_LSB +: CMTR_TD_CODE_W];
            end
            else if (wr && paddr == CMTR_OFF_CURRENT_TRANSMIT_STATE)
            begin
                current_transmit_state_q <= pwdata[2:0];
            end
        end
    end

    // Sticky flags: hardware set beats a write-one clear in the same cycle
    // so an event is never lost to a clear that races it
    assign tco_set = trig;
    assign cse_set = tco_set && !trigger_occurred_q && trigger_occurred_mask_q;

    // Trigger occurred flag, write one to clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trigger_occurred_q <= 1'b0;
        end
        else if (ce)
        begin
            if (tco_set)
            begin
                trigger_occurred_q <= 1'b1;
            end
            else if (wr && paddr == CMTR_OFF_CMT_CONDITION &&
                     pwdata[CMTR_TRIGGER_OCCURRED_BIT])
            begin
                trigger_occurred_q <= 1'b0;
            end
        end
    end

    // Service event, set only as the trigger flag goes from clear to set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            connection_service_event_q <= 1'b0;
        end
        else if (ce)
        begin
            if (cse_set)
            begin
                connection_service_event_q <= 1'b1;
            end
            else if (wr && paddr == CMTR_OFF_RECEIVE_CONDITION_B &&
                     pwdata[CMTR_CONNECTION_SERVICE_EVENT_BIT])
            begin
                connection_service_event_q <= 1'b0;
            end
        end
    end

    // Level interrupt from the unmasked service event
    // Stays high until software clears the event or masks it
    assign irq = connection_service_event_q && connection_service_event_mask_q;

    // Outputs straight from registers
    // No logic between these flops and the pins
    assign tx_line_state = current_transmit_state_q;
    assign switch_config = switch_configuration_q;
    assign trigger_pulse = trigger_pulse_q;

endmodule : cmtr_trigger_reaction
`default_nettype wire

// *** hw/cmtr_pkg.sv ***
// Constants for the connection-management trigger reaction block.
// Assumes a 32-bit APB slave with one aligned word per register.
package cmtr_pkg;

    // Register byte offsets
    localparam logic [7:0] CMTR_OFF_TRIGGER_DEFINITION = 8'h00;
    localparam logic [7:0] CMTR_OFF_TRIGGER_TRANSITION_CONFIG = 8'h04;
    localparam logic [7:0] CMTR_OFF_SWITCH_CONFIGURATION = 8'h08;
    localparam logic [7:0] CMTR_OFF_CURRENT_TRANSMIT_STATE = 8'h0C;
    localparam logic [7:0] CMTR_OFF_CMT_CONDITION = 8'h10;
    localparam logic [7:0] CMTR_OFF_CMT_CONDITION_COMPARE = 8'h14;
    localparam logic [7:0] CMTR_OFF_CMT_CONDITION_MASK = 8'h18;
    localparam logic [7:0] CMTR_OFF_RECEIVE_CONDITION_B = 8'h1C;
    localparam logic [7:0] CMTR_OFF_RECEIVE_CONDITION_MASK_B = 8'h20;

    // Trigger definition fields
    localparam int CMTR_TD_CODE_LSB = 0;
    localparam int CMTR_TD_CODE_W = 3;
    localparam int CMTR_TD_EN_LSB = 3;
    localparam int CMTR_NUM_COND = 5;

    // Condition bit order inside the enable field and the condition vector
    localparam int CMTR_COND_NOISE_THRESHOLD = 0;
    localparam int CMTR_COND_QUIET = 1;
    localparam int CMTR_COND_HALT = 2;
    localparam int CMTR_COND_MASTER = 3;
    localparam int CMTR_COND_SUPER_IDLE = 4;

    // Flag positions
    localparam int CMTR_TRIGGER_OCCURRED_BIT = 0;
    localparam int CMTR_CONNECTION_SERVICE_EVENT_BIT = 0;

    // Transmit line-state code for quiet
    localparam logic [2:0] CMTR_TX_QUIET = 3'h6;

    // Reset values
    localparam logic [7:0] CMTR_RST_TRIGGER_DEFINITION = 8'h00;
    localparam logic [7:0] CMTR_RST_TRANSITION_CONFIG = 8'h00;
    localparam logic [7:0] CMTR_RST_SWITCH_CONFIGURATION = 8'h00;
    localparam logic [2:0] CMTR_RST_TRANSMIT_STATE = 3'h0;
    localparam logic [7:0] CMTR_RST_BYTE = 8'h00;

    // Reaction limit for line state and switch reload
    localparam int CMTR_REACT_LIMIT_US = 3000;

endpackage : cmtr_pkg

// *** hw/cmtr_cond_if.sv ***
// Carries the synchronised received conditions from the synchroniser
// to the trigger logic. Both ends sit on pclk.
`timescale 1ns/1ps
`default_nettype none
interface cmtr_cond_if #(parameter int W = 5);
    logic [W-1:0] cond;
    modport src (output cond);
    modport snk (input cond);
endinterface : cmtr_cond_if
`default_nettype wire

// *** hw/cmtr_sync.sv ***
// Two-flop synchroniser for a vector of level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
`default_nettype none
module cmtr_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Raw levels and synchronised result
    input wire logic [W-1:0] raw,
    cmtr_cond_if.src out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (ce)
        begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    assign out.cond = sync_q;
endmodule : cmtr_sync
`default_nettype wire

// *** testbench/cmtr_trigger_reaction_chk.sv ***
// Port-level assertions for the trigger reaction block.
// Assumes one pclk domain; bound into every cmtr_trigger_reaction.
`timescale 1ns/1ps
`default_nettype none
module cmtr_trigger_reaction_chk #(
    parameter int NUM_COND = 5
) (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Conditions and reactions
    input wire logic rx_super_idle,
    input wire logic rx_master,
    input wire logic rx_halt,
    input wire logic rx_quiet,
    input wire logic rx_noise_threshold,
    input wire logic [2:0] tx_line_state,
    input wire logic [7:0] switch_config,
    input wire logic trigger_pulse,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Any raw condition, enabled or not
    logic rx_any;
    logic wr_taken;
    assign rx_any = rx_super_idle | rx_master | rx_halt | rx_quiet | rx_noise_threshold;
    assign wr_taken = psel & penable & pwrite & ce;
    // Pulse lasts exactly one cycle
    sequence pulse_ends;
        trigger_pulse ##1 !trigger_pulse;
    endsequence
    pulse_once_a: assert property ($rose(trigger_pulse) |-> pulse_ends)
        else $error("trigger pulse longer than one cycle");
    // Two sync flops plus trigger cycle: cause seen three edges back
    trig_cause_a: assert property (trigger_pulse |-> $past(rx_any, 3))
        else $error("trigger without a received condition");
    tx_source_a: assert property (!$stable(tx_line_state) |-> trigger_pulse || $past(wr_taken))
        else $error("transmit state changed without cause");
    sw_source_a: assert property (!$stable(switch_config) |-> trigger_pulse || $past(wr_taken))
        else $error("switch setting changed without cause");
    irq_source_a: assert property ($rose(irq) |-> trigger_pulse || $past(wr_taken))
        else $error("interrupt rose without cause");
    ready_ce_a: assert property (pready == ce)
        else $error("pready differs from ce");
    freeze_ce_a: assert property (!ce |=> $stable(tx_line_state) && $stable(switch_config) && $stable(irq))
        else $error("outputs moved while clock enable low");
    err_access_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access");
    bad_read_zero_a: assert property (psel && penable && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : cmtr_trigger_reaction_chk
bind cmtr_trigger_reaction cmtr_trigger_reaction_chk #(.NUM_COND(NUM_COND)) i_chk (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .rx_super_idle, .rx_master, .rx_halt, .rx_quiet, .rx_noise_threshold,
    .tx_line_state, .switch_config, .trigger_pulse, .irq);
`default_nettype wire

// *** testbench/cmtr_trigger_reaction_tb.sv ***
// Self-checking bench for the trigger reaction block over APB.
// Assumes zero-wait APB and a three-edge condition to output latency.
`timescale 1ns/1ps
`default_nettype none
module cmtr_trigger_reaction_tb;
    import cmtr_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic err;
    logic [4:0] rx = 5'h00;
    logic [2:0] tx_line_state;
    logic [2:0] code;
    logic [7:0] switch_config;
    logic trigger_pulse;
    logic irq;
    logic [31:0] r;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;

    cmtr_trigger_reaction i_cmtr_trigger_reaction (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rx_super_idle(rx[4]), .rx_master(rx[3]), .rx_halt(rx[2]),
        .rx_quiet(rx[1]), .rx_noise_threshold(rx[0]), .tx_line_state, .switch_config,
        .trigger_pulse, .irq);

    // 40 MHz
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end

    task wrap_up;
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH at %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask : rd

    // Flag updates land on the write edge, so look one edge later
    task ck_irq(input logic e);
        @(posedge pclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : ck_irq

    // Hang guard, far above the few hundred cycles needed
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            failures++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(CMTR_OFF_TRIGGER_DEFINITION, 32'h0);
        rd(CMTR_OFF_SWITCH_CONFIGURATION, 32'h0);
        rd(CMTR_OFF_CMT_CONDITION, 32'h0);
        rd(8'h24, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, CMTR_OFF_CMT_CONDITION_COMPARE, 32'h5A);
        rd(CMTR_OFF_CMT_CONDITION_COMPARE, 32'h5A);
        apb(1'b1, CMTR_OFF_SWITCH_CONFIGURATION, 32'h3C);
        rd(CMTR_OFF_SWITCH_CONFIGURATION, 32'h3C);
        apb(1'b1, CMTR_OFF_CURRENT_TRANSMIT_STATE, 32'hFF);
        rd(CMTR_OFF_CURRENT_TRANSMIT_STATE, 32'h7);
        // Every condition alone, quiet code on the last
        for (int i = 0; i < 5; i++)
        begin
            code = (i == 4) ? CMTR_TX_QUIET : 3'(i + 1);
            apb(1'b1, CMTR_OFF_TRIGGER_DEFINITION, 32'(8'h08 << i) | 32'(code));
            apb(1'b1, CMTR_OFF_TRIGGER_TRANSITION_CONFIG, 32'hA0 + 32'(i));
            rx <= 5'(1 << i);
            repeat (4) @(posedge pclk);
            chk(32'(tx_line_state), 32'(code));
            chk(32'(switch_config), 32'hA0 + 32'(i));
            chk({31'h0, trigger_pulse}, 32'h1);
            rd(CMTR_OFF_CMT_CONDITION, 32'h1);
            rx <= 5'h00;
            apb(1'b1, CMTR_OFF_CMT_CONDITION, 32'h1);
            rd(CMTR_OFF_CMT_CONDITION, 32'h0);
        end
        // Disabled condition ignored, then a persistent one fires once
        apb(1'b1, CMTR_OFF_TRIGGER_DEFINITION, 32'h25);
        apb(1'b1, CMTR_OFF_CURRENT_TRANSMIT_STATE, 32'h0);
        rx <= 5'h02;
        repeat (4) @(posedge pclk);
        chk(32'(tx_line_state), 32'h0);
        rx <= 5'h06;
        repeat (4) @(posedge pclk);
        chk(32'(tx_line_state), 32'h5);
        apb(1'b1, CMTR_OFF_CURRENT_TRANSMIT_STATE, 32'h2);
        repeat (4) @(posedge pclk);
        rd(CMTR_OFF_CURRENT_TRANSMIT_STATE, 32'h2);
        rx <= 5'h00;
        apb(1'b1, CMTR_OFF_CMT_CONDITION, 32'h1);
        // Leaving the active state: quiet on halt, quiet or noise, switch kept,
        // a switch write in the trigger cycle dropped, interrupt raised
        apb(1'b1, CMTR_OFF_CMT_CONDITION_MASK, 32'h1);
        apb(1'b1, CMTR_OFF_RECEIVE_CONDITION_MASK_B, 32'h1);
        apb(1'b1, CMTR_OFF_TRIGGER_TRANSITION_CONFIG, 32'hA4);
        apb(1'b1, CMTR_OFF_TRIGGER_DEFINITION, 32'h3E);
        rx <= 5'h01;
        apb(1'b1, CMTR_OFF_SWITCH_CONFIGURATION, 32'h55);
        @(posedge pclk);
        chk(32'(switch_config), 32'hA4);
        chk(32'(tx_line_state), 32'(CMTR_TX_QUIET));
        chk({31'h0, irq}, 32'h1);
        rd(CMTR_OFF_RECEIVE_CONDITION_B, 32'h1);
        apb(1'b1, CMTR_OFF_RECEIVE_CONDITION_MASK_B, 32'h0);
        ck_irq(1'b0);
        apb(1'b1, CMTR_OFF_RECEIVE_CONDITION_MASK_B, 32'h1);
        ck_irq(1'b1);
        apb(1'b1, CMTR_OFF_RECEIVE_CONDITION_B, 32'h1);
        ck_irq(1'b0);
        rx <= 5'h00;
        // Clock enable low stalls the bus
        ce <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        chk({31'h0, pready}, 32'h0);
        ce <= 1'b1;
        wrap_up();
    end
endmodule : cmtr_trigger_reaction_tb
`default_nettype wire
